/* File: core/wdt_cnt_if.sv */
`timescale 1ns/1ps
interface wdt_cnt_if;
    logic       tick;
    logic       restart;
    logic       run;
    logic [3:0] prescale;
    logic       timeout;
    modport ctl (output tick, output restart, output run, output prescale, input timeout);
    modport cnt (input tick, input restart, input run, input prescale, output timeout);
endinterface

/* File: core/wdt_counter.sv */
`timescale 1ns/1ps
module wdt_counter
    import wdt_pkg::*;
#(
    parameter logic [COUNT_W-1:0] P_BASE = COUNT_W'(TIMEOUT_BASE)
) (
    // System side
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    // Control link
    wdt_cnt_if.cnt    link
);
    logic [COUNT_W-1:0] count;
    logic [COUNT_W-1:0] limit;
    logic [3:0]         code;

    // Reserved codes fall back to the longest period rather than a short one
    assign code  = (link.prescale > PRESC_MAX_CODE) ? PRESC_MAX_CODE : link.prescale;
    assign limit = P_BASE << code;

    // ****************************************
    // Oscillator cycle counter
    // ****************************************
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            count        <= '0;
            link.timeout <= 1'b0;
        end else begin
            link.timeout <= 1'b0;
            if (link.restart || !link.run) begin
                count <= '0;
            end else if (link.tick) begin
                if (count >= limit - COUNT_W'(1)) begin
                    count        <= '0;
                    link.timeout <= 1'b1;
                end else begin
                    count <= count + COUNT_W'(1);
                end
            end
        end
    end
endmodule

/* File: core/wdt_edge_sync.sv */
`timescale 1ns/1ps
module wdt_edge_sync
    import wdt_pkg::*;
(
    // System side
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    // Asynchronous level in, one-cycle rise pulse out
    input  wire logic i_async,
    output logic      o_rise
);
    logic stage1;
    logic stage2;
    logic stage3;

    // First stage feeds only the second; edge taken from later stages
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            stage1 <= 1'b0;
            stage2 <= 1'b0;
            stage3 <= 1'b0;
        end else begin
            stage1 <= i_async;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    assign o_rise = stage2 & ~stage3;
endmodule

/* File: core/wdt_pkg.sv */
package wdt_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] OFF_RESET_CAUSE    = 8'h00;
    localparam logic [7:0] OFF_CONTROL_STATUS = 8'h04;

    // Reset-cause bits
    localparam int BIT_POWER_ON  = 0;
    localparam int BIT_EXTERNAL  = 1;
    localparam int BIT_BROWNOUT  = 2;
    localparam int BIT_WDT_RESET = 3;
    localparam logic [3:0] CAUSE_POR_VALUE = 4'h1;

    // Control/status bits
    localparam int BIT_IRQ_FLAG   = 7;
    localparam int BIT_IRQ_ENABLE = 6;
    localparam int BIT_PRESC_3    = 5;
    localparam int BIT_CHANGE_EN  = 4;
    localparam int BIT_RESET_EN   = 3;
    localparam int BIT_PRESC_LO   = 0;

    // ****************************************
    // Timing
    // ****************************************
    localparam int          CLK_HZ            = 10_000_000;
    localparam int          OSC_HZ            = 128_000;
    localparam logic [2:0]  CE_WINDOW_CYCLES  = 3'h4;
    localparam int          TIMEOUT_BASE      = 2048;
    localparam logic [3:0]  PRESC_MAX_CODE    = 4'h9;
    localparam int          COUNT_W           = 21;

    typedef enum logic [1:0] {
        MODE_STOPPED,
        MODE_INT,
        MODE_RESET,
        MODE_INT_RESET
    } wdt_mode_type;

endpackage

/* File: core/wdt_top.sv */
// Chosen here: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module wdt_top
    import wdt_pkg::*;
#(
    parameter logic [COUNT_W-1:0] P_TIMEOUT_BASE = COUNT_W'(TIMEOUT_BASE)
) (
    // Clock and power-on reset
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    // AHB-Lite slave
    input  wire logic        i_hsel,
    input  wire logic [31:0] i_haddr,
    input  wire logic [1:0]  i_htrans,
    input  wire logic        i_hwrite,
    input  wire logic [2:0]  i_hsize,
    input  wire logic [31:0] i_hwdata,
    input  wire logic        i_hready,
    output logic             o_hreadyout,
    output logic             o_hresp,
    output logic [31:0]      o_hrdata,
    // Watchdog oscillator and fuse
    input  wire logic        i_wdt_osc,
    input  wire logic        i_always_on_fuse,
    // Core interface
    input  wire logic        i_restart,
    input  wire logic        i_global_int_enable,
    input  wire logic        i_vector_ack,
    output logic             o_wdt_irq,
    // Other reset sources and watchdog reset out
    input  wire logic        i_external_rst,
    input  wire logic        i_brownout_rst,
    output logic             o_sys_reset
);

    // ****************************************
    // State
    // ****************************************
    logic [3:0]   cause;
    logic         irq_flag;
    logic         irq_enable;
    logic         change_en;
    logic [2:0]   ce_count;
    logic         reset_en;
    logic [3:0]   prescale;

    logic [3:0]   next_cause;
    logic         next_irq_flag;
    logic         next_irq_enable;
    logic         next_change_en;
    logic [2:0]   next_ce_count;
    logic         next_reset_en;
    logic [3:0]   next_prescale;

    logic         wr_pending;
    logic [7:0]   wr_addr;
    logic         wr_cause;
    logic         wr_ctrl;
    logic [7:0]   wdata;
    logic         addr_valid;

    logic         fuse_prog;
    logic         eff_reset_en;
    logic         eff_irq_enable;
    wdt_mode_type mode;
    logic         timeout;
    logic         set_flag;
    logic         fire;
    logic         sys_event;
    logic         osc_rise;
    logic [7:0]   rd_value;

    wdt_cnt_if cnt_link ();

    // ****************************************
    // Oscillator crossing and counter
    // ****************************************
    wdt_edge_sync u_osc_sync (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_async (i_wdt_osc),
        .o_rise  (osc_rise)
    );

    // Counter and all of its control stay in the system clock domain
    wdt_counter #(
        .P_BASE (P_TIMEOUT_BASE)
    ) u_counter (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .link    (cnt_link)
    );

    // Restart acts in the system domain; the oscillator enters only as a tick
    assign cnt_link.tick     = osc_rise;
    assign cnt_link.restart  = i_restart | sys_event;
    assign cnt_link.run      = (mode != MODE_STOPPED);
    assign cnt_link.prescale = prescale;
    assign timeout           = cnt_link.timeout;

    // ****************************************
    // Mode decode
    // ****************************************
    // A programmed fuse reads 0 and wins over both enable bits
    assign fuse_prog      = ~i_always_on_fuse;
    assign eff_reset_en   = reset_en | cause[BIT_WDT_RESET] | fuse_prog;
    assign eff_irq_enable = irq_enable & ~fuse_prog;

    always_comb begin
        unique case ({eff_reset_en, eff_irq_enable})
            2'b00:   mode = MODE_STOPPED;
            2'b01:   mode = MODE_INT;
            2'b10:   mode = MODE_RESET;
            2'b11:   mode = MODE_INT_RESET;
        endcase
    end

    // First timeout in combined mode only flags; a second unserviced one resets
    assign set_flag = timeout & ((mode == MODE_INT) |
                                 ((mode == MODE_INT_RESET) & ~irq_flag));
    assign fire     = timeout & ((mode == MODE_RESET) |
                                 ((mode == MODE_INT_RESET) & irq_flag));
    assign sys_event = fire | i_external_rst | i_brownout_rst;

    // ****************************************
    // AHB-Lite address phase
    // ****************************************
    // Size is not decoded: only whole-word accesses are expected
    assign addr_valid = i_hsel & i_htrans[1] & i_hready;
    assign wr_cause   = wr_pending & (wr_addr == OFF_RESET_CAUSE);
    assign wr_ctrl    = wr_pending & (wr_addr == OFF_CONTROL_STATUS);
    assign wdata      = i_hwdata[7:0];

    // Write strobe for the data phase that follows a taken write address phase
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            wr_pending <= 1'b0;
        end else begin
            wr_pending <= addr_valid & i_hwrite;
        end
    end

    // Address kept every cycle; it only matters while the strobe above is set
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            wr_addr <= 8'h00;
        end else begin
            wr_addr <= i_haddr[7:0];
        end
    end

    // ****************************************
    // Reset-cause next state
    // ****************************************
    always_comb begin
        next_cause = cause;
        if (wr_cause) begin
            next_cause = cause & wdata[3:0];
        end
        // Hardware set wins over a same-cycle software clear
        if (i_external_rst) begin
            next_cause[BIT_EXTERNAL] = 1'b1;
        end
        if (i_brownout_rst) begin
            next_cause[BIT_BROWNOUT] = 1'b1;
        end
        if (fire) begin
            next_cause[BIT_WDT_RESET] = 1'b1;
        end
    end

    // One flop per cause bit; power-on leaves only the power-on bit set
    for (genvar gi = 0; gi < 4; gi++) begin : g_cause
        always_ff @(posedge i_clk) begin
            if (!i_rst_n) begin
                cause[gi] <= CAUSE_POR_VALUE[gi];
            end else begin
                cause[gi] <= next_cause[gi];
            end
        end
    end

    // ****************************************
    // Control/status next state
    // ****************************************
    always_comb begin
        next_irq_flag   = irq_flag;
        next_irq_enable = irq_enable;
        next_change_en  = change_en;
        next_ce_count   = ce_count;
        next_reset_en   = reset_en;
        next_prescale   = prescale;

        // Window counts down from the write and closes as the count reaches zero
        if (ce_count != 3'h0) begin
            next_ce_count = ce_count - 3'h1;
            if (ce_count == 3'h1) begin
                next_change_en = 1'b0;
            end
        end

        if (wr_ctrl) begin
            if (wdata[BIT_IRQ_FLAG]) begin
                next_irq_flag = 1'b0;
            end
            next_irq_enable = wdata[BIT_IRQ_ENABLE];
            // Outside the window reset-enable may only be set, never cleared
            if (change_en) begin
                next_prescale = {wdata[BIT_PRESC_3], wdata[BIT_PRESC_LO+2:BIT_PRESC_LO]};
                // Clear refused while the watchdog cause flag still pins it
                next_reset_en = wdata[BIT_RESET_EN] |
                                (reset_en & cause[BIT_WDT_RESET]);
            end else begin
                next_reset_en = reset_en | wdata[BIT_RESET_EN];
            end
            if (wdata[BIT_CHANGE_EN]) begin
                next_change_en = 1'b1;
                next_ce_count  = CE_WINDOW_CYCLES;
            end else begin
                next_change_en = 1'b0;
                next_ce_count  = 3'h0;
            end
        end

        if (i_vector_ack) begin
            next_irq_flag = 1'b0;
            if (mode == MODE_INT_RESET) begin
                next_irq_enable = 1'b0;
            end
        end

        if (set_flag) begin
            next_irq_flag = 1'b1;
        end

        // Any system reset returns the control bits to their defaults
        if (sys_event) begin
            next_irq_flag   = 1'b0;
            next_irq_enable = 1'b0;
            next_change_en  = 1'b0;
            next_ce_count   = 3'h0;
            next_reset_en   = 1'b0;
            next_prescale   = 4'h0;
        end
    end

    // ****************************************
    // Interrupt flag and enable
    // ****************************************
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            irq_flag <= 1'b0;
        end else begin
            irq_flag <= next_irq_flag;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            irq_enable <= 1'b0;
        end else begin
            irq_enable <= next_irq_enable;
        end
    end

    // ****************************************
    // Change window
    // ****************************************
    // Flag and down-counter share one process so they can never disagree
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            change_en <= 1'b0;
            ce_count  <= 3'h0;
        end else begin
            change_en <= next_change_en;
            ce_count  <= next_ce_count;
        end
    end

    // ****************************************
    // Reset enable and prescaler
    // ****************************************
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            reset_en <= 1'b0;
        end else begin
            reset_en <= next_reset_en;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            prescale <= 4'h0;
        end else begin
            prescale <= next_prescale;
        end
    end

    // ****************************************
    // Read path
    // ****************************************
    // Read data come from next-state values so a read right after a write sees it
    always_comb begin
        rd_value = 8'h00;
        if (i_haddr[7:0] == OFF_RESET_CAUSE) begin
            rd_value = {4'h0, next_cause};
        end else if (i_haddr[7:0] == OFF_CONTROL_STATUS) begin
            rd_value[BIT_IRQ_FLAG]   = next_irq_flag;
            rd_value[BIT_IRQ_ENABLE] = next_irq_enable & ~fuse_prog;
            rd_value[BIT_PRESC_3]    = next_prescale[3];
            rd_value[BIT_CHANGE_EN]  = next_change_en;
            rd_value[BIT_RESET_EN]   = next_reset_en | next_cause[BIT_WDT_RESET] |
                                       fuse_prog;
            rd_value[BIT_PRESC_LO+2:BIT_PRESC_LO] = next_prescale[2:0];
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_hrdata <= 32'h0000_0000;
        end else if (addr_valid && !i_hwrite) begin
            o_hrdata <= {24'h00_0000, rd_value};
        end
    end

    // Zero wait states: every register answers in its data phase
    assign o_hreadyout = 1'b1;
    assign o_hresp     = 1'b0;

    // ****************************************
    // Interrupt request
    // ****************************************
    // Level output: it drops at once when the core masks interrupts globally
    assign o_wdt_irq = irq_flag & eff_irq_enable & i_global_int_enable;

    // ****************************************
    // System reset pulse
    // ****************************************
    // Registered so the pulse is free of glitches and exactly one clock wide

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_sys_reset <= 1'b0;
        end else begin
            o_sys_reset <= fire;
        end
    end

endmodule

/* File: test/wdt_top_assertions.sv */
`timescale 1ns/1ps
module wdt_top_assertions
    import wdt_pkg::*;
#(
    parameter logic [COUNT_W-1:0] P_TIMEOUT_BASE = COUNT_W'(TIMEOUT_BASE)
) (
    // Clock and reset
    input wire logic        i_clk,
    input wire logic        i_rst_n,
    // Bus
    input wire logic        i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0]  i_htrans,
    input wire logic        i_hwrite,
    input wire logic        i_hready,
    input wire logic        o_hreadyout,
    input wire logic        o_hresp,
    input wire logic [31:0] o_hrdata,
    // Core and reset events
    input wire logic        i_always_on_fuse,
    input wire logic        i_global_int_enable,
    input wire logic        i_vector_ack,
    input wire logic        i_external_rst,
    input wire logic        i_brownout_rst,
    input wire logic        o_wdt_irq,
    input wire logic        o_sys_reset
);
    // ****************************************
    // Read tracking
    // ****************************************
    logic rd_cause;
    logic rd_ctrl;
    logic rd_take;
    assign rd_take = i_hsel && i_htrans[1] && i_hready && !i_hwrite;
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            rd_cause <= 1'b0;
            rd_ctrl  <= 1'b0;
        end else begin
            rd_cause <= rd_take && (i_haddr[7:0] == OFF_RESET_CAUSE);
            rd_ctrl  <= rd_take && (i_haddr[7:0] == OFF_CONTROL_STATUS);
        end
    end

    // ****************************************
    // Properties
    // ****************************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    a_resp_okay: assert property (o_hresp == 1'b0) else $error("hresp not okay");
    a_ready_high: assert property (o_hreadyout == 1'b1) else $error("hreadyout low");
    a_cause_upper_zero: assert property (rd_cause |-> o_hrdata[31:4] == 28'h0000000)
        else $error("reset cause upper bits not zero");
    a_ctrl_upper_zero: assert property (rd_ctrl |-> o_hrdata[31:8] == 24'h000000)
        else $error("control upper bits not zero");
    a_fuse_forces_bits: assert property (rd_ctrl && !i_always_on_fuse &&
        !$past(i_always_on_fuse) |-> o_hrdata[3] && !o_hrdata[6])
        else $error("fuse did not force enable bits");
    a_sysrst_one_cycle: assert property (o_sys_reset |=> !o_sys_reset)
        else $error("system reset longer than one cycle");
    a_irq_needs_gie: assert property (o_wdt_irq |-> i_global_int_enable)
        else $error("irq without global enable");
    a_fuse_no_irq: assert property (!i_always_on_fuse |-> !o_wdt_irq)
        else $error("irq while fuse forces reset mode");
    a_ack_clears_irq: assert property (o_wdt_irq && i_vector_ack |=> !o_wdt_irq)
        else $error("vector ack did not clear irq");
    a_event_clears_irq: assert property (i_external_rst || i_brownout_rst |=> !o_wdt_irq)
        else $error("reset event left irq high");
    a_reset_quiet: assert property ($rose(i_rst_n) |->
        !o_sys_reset && !o_wdt_irq && o_hrdata == 32'h00000000)
        else $error("outputs not quiet after reset");

    c_irq_rise: cover property ($rose(o_wdt_irq));
    c_sys_reset: cover property (o_sys_reset);
    c_ack_irq: cover property (o_wdt_irq && i_vector_ack);
endmodule

bind wdt_top wdt_top_assertions #(.P_TIMEOUT_BASE(P_TIMEOUT_BASE)) chk_u (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_hsel(i_hsel), .i_haddr(i_haddr),
    .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hready(i_hready),
    .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .o_hrdata(o_hrdata),
    .i_always_on_fuse(i_always_on_fuse), .i_global_int_enable(i_global_int_enable),
    .i_vector_ack(i_vector_ack), .i_external_rst(i_external_rst),
    .i_brownout_rst(i_brownout_rst), .o_wdt_irq(o_wdt_irq), .o_sys_reset(o_sys_reset)
);

/* File: test/wdt_top_tb.sv */
`timescale 1ns/1ps
module wdt_top_tb
    import wdt_pkg::*;
;
    typedef struct packed {logic w; logic [7:0] a; logic [7:0] d; logic [7:0] e;} wdt_row_type;
    localparam wdt_row_type ROWS [9] = '{
        '{1'b0, 8'h00, 8'h00, 8'h01}, '{1'b1, 8'h00, 8'hFF, 8'h01},
        '{1'b0, 8'h04, 8'h00, 8'h00}, '{1'b1, 8'h08, 8'hFF, 8'h00},
        '{1'b1, 8'h04, 8'h40, 8'h40}, '{1'b1, 8'h04, 8'h00, 8'h00},
        '{1'b1, 8'h04, 8'h08, 8'h08}, '{1'b1, 8'h04, 8'h00, 8'h08},
        '{1'b1, 8'h04, 8'h0D, 8'h08}};
    logic        i_clk, i_rst_n, i_hsel, i_hwrite, i_wdt_osc, i_always_on_fuse;
    logic        i_restart, i_global_int_enable, i_vector_ack, i_external_rst;
    logic        i_brownout_rst, o_hreadyout, o_hresp, o_wdt_irq, o_sys_reset;
    logic [31:0] i_haddr, i_hwdata, o_hrdata, rdat;
    logic [1:0]  i_htrans;
    logic [2:0]  i_hsize;
    int          miscompares = 0;
    int          num_checks = 0;
    int          rst_cnt = 0;

    wdt_top #(.P_TIMEOUT_BASE(21'h4)) dut_u (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_hsel(i_hsel), .i_haddr(i_haddr),
        .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(i_hsize), .i_hwdata(i_hwdata),
        .i_hready(o_hreadyout), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
        .o_hrdata(o_hrdata), .i_wdt_osc(i_wdt_osc), .i_always_on_fuse(i_always_on_fuse),
        .i_restart(i_restart), .i_global_int_enable(i_global_int_enable),
        .i_vector_ack(i_vector_ack), .o_wdt_irq(o_wdt_irq), .i_external_rst(i_external_rst),
        .i_brownout_rst(i_brownout_rst), .o_sys_reset(o_sys_reset));

    // ****************************************
    // Helpers
    // ****************************************
    initial begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end
    always @(posedge i_clk) if (o_sys_reset === 1'b1) rst_cnt <= rst_cnt + 1;
    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", n, exp, seen);
        end
    endtask
    // Address phase held until hready, then data phase held until hready
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_hsel <= 1'b1; i_htrans <= 2'b10; i_hwrite <= w; i_haddr <= {24'h000000, a};
        do @(posedge i_clk); while (o_hreadyout !== 1'b1);
        i_hsel <= 1'b0; i_htrans <= 2'b00; i_hwdata <= {24'h000000, d};
        do @(posedge i_clk); while (o_hreadyout !== 1'b1);
        rdat = o_hrdata;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        xfer(1'b0, a, 8'h00);
        chk("read", rdat, {24'h000000, e});
    endtask
    // Opens the change window with the old prescaler kept, then writes
    task automatic prot(input logic [7:0] keep, input logic [7:0] d);
        xfer(1'b1, OFF_CONTROL_STATUS, 8'h18 | keep);
        xfer(1'b1, OFF_CONTROL_STATUS, d);
    endtask
    task automatic osc(input int n);
        repeat (n) begin
            repeat (4) @(posedge i_clk);
            i_wdt_osc <= 1'b1;
            repeat (4) @(posedge i_clk);
            i_wdt_osc <= 1'b0;
        end
        repeat (8) @(posedge i_clk);
    endtask
    task automatic wait_irq();
        while (o_wdt_irq !== 1'b1) @(posedge i_clk);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        #(100 * 30000);
        miscompares++;
        tally_and_finish();
    end

    // ****************************************
    // Tests
    // ****************************************
    initial begin
        {i_rst_n, i_hsel, i_hwrite, i_wdt_osc, i_restart, i_vector_ack} = 6'h00;
        {i_external_rst, i_brownout_rst, i_global_int_enable} = 3'h0;
        i_always_on_fuse = 1'b1; i_haddr = 32'h0; i_hwdata = 32'h0;
        i_htrans = 2'b00; i_hsize = 3'b010;
        repeat (10) @(posedge i_clk);
        i_rst_n <= 1'b1;
        foreach (ROWS[k]) begin
            if (ROWS[k].w) xfer(1'b1, ROWS[k].a, ROWS[k].d);
            rdc(ROWS[k].a, ROWS[k].e);
        end
        $display("table done");
        prot(8'h00, 8'h05);
        rdc(OFF_CONTROL_STATUS, 8'h05);
        xfer(1'b1, OFF_CONTROL_STATUS, 8'h00);
        rdc(OFF_CONTROL_STATUS, 8'h05);
        xfer(1'b1, OFF_CONTROL_STATUS, 8'h1D);
        repeat (6) @(posedge i_clk);
        xfer(1'b1, OFF_CONTROL_STATUS, 8'h00);
        rdc(OFF_CONTROL_STATUS, 8'h0D);
        prot(8'h05, 8'h00);
        rdc(OFF_CONTROL_STATUS, 8'h00);
        $display("change window done");
        xfer(1'b1, OFF_CONTROL_STATUS, 8'h40);
        i_global_int_enable <= 1'b1;
        osc(3);
        chk("irq early", o_wdt_irq, 1'b0);
        osc(1);
        chk("irq", o_wdt_irq, 1'b1);
        i_global_int_enable <= 1'b0;
        repeat (2) @(posedge i_clk);
        chk("irq gated", o_wdt_irq, 1'b0);
        i_global_int_enable <= 1'b1;
        i_vector_ack <= 1'b1;
        @(posedge i_clk);
        i_vector_ack <= 1'b0;
        @(posedge i_clk);
        chk("irq ack", o_wdt_irq, 1'b0);
        rdc(OFF_CONTROL_STATUS, 8'h40);
        osc(4);
        wait_irq();
        xfer(1'b1, OFF_CONTROL_STATUS, 8'hC0);
        rdc(OFF_CONTROL_STATUS, 8'h40);
        chk("no reset", rst_cnt, 0);
        $display("interrupt mode done");
        xfer(1'b1, OFF_CONTROL_STATUS, 8'h48);
        osc(4);
        wait_irq();
        rdc(OFF_CONTROL_STATUS, 8'hC8);
        i_vector_ack <= 1'b1;
        @(posedge i_clk);
        i_vector_ack <= 1'b0;
        rdc(OFF_CONTROL_STATUS, 8'h08);
        xfer(1'b1, OFF_CONTROL_STATUS, 8'h48);
        osc(4);
        wait_irq();
        osc(4);
        chk("combined reset", rst_cnt, 1);
        rdc(OFF_RESET_CAUSE, 8'h09);
        prot(8'h00, 8'h00);
        rdc(OFF_CONTROL_STATUS, 8'h08);
        xfer(1'b1, OFF_RESET_CAUSE, 8'h01);
        prot(8'h00, 8'h00);
        rdc(OFF_CONTROL_STATUS, 8'h00);
        $display("combined mode done");
        i_restart <= 1'b1;
        @(posedge i_clk);
        i_restart <= 1'b0;
        prot(8'h00, 8'h09);
        i_restart <= 1'b1;
        @(posedge i_clk);
        i_restart <= 1'b0;
        osc(6);
        i_restart <= 1'b1;
        @(posedge i_clk);
        i_restart <= 1'b0;
        osc(7);
        chk("restart held off", rst_cnt, 1);
        osc(1);
        chk("code one period", rst_cnt, 2);
        xfer(1'b1, OFF_RESET_CAUSE, 8'h00);
        rdc(OFF_RESET_CAUSE, 8'h00);
        prot(8'h00, 8'h00);
        $display("period done");
        i_external_rst <= 1'b1;
        @(posedge i_clk);
        i_external_rst <= 1'b0;
        rdc(OFF_RESET_CAUSE, 8'h02);
        i_brownout_rst <= 1'b1;
        @(posedge i_clk);
        i_brownout_rst <= 1'b0;
        rdc(OFF_RESET_CAUSE, 8'h06);
        xfer(1'b1, OFF_RESET_CAUSE, 8'h00);
        rdc(OFF_RESET_CAUSE, 8'h00);
        $display("reset causes done");
        i_always_on_fuse <= 1'b0;
        rdc(OFF_CONTROL_STATUS, 8'h08);
        xfer(1'b1, OFF_CONTROL_STATUS, 8'h40);
        rdc(OFF_CONTROL_STATUS, 8'h08);
        osc(4);
        chk("fuse reset", rst_cnt, 3);
        i_always_on_fuse <= 1'b1;
        i_rst_n <= 1'b0;
        repeat (2) @(posedge i_clk);
        i_rst_n <= 1'b1;
        rdc(OFF_RESET_CAUSE, 8'h01);
        rdc(OFF_CONTROL_STATUS, 8'h00);
        $display("fuse and reset done");
        tally_and_finish();
    end
endmodule
